//--- logic/ums_pkg.sv
package ums_pkg;

    // ------------------------------------------------------------
    // register byte addresses on the apb bus
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODEM_STATUS = 8'h00; // read: status, write: delay
    localparam logic [7:0] ADDR_SCRATCH = 8'h04;
    localparam logic [7:0] ADDR_FEATURE = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0c;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] SCRATCH_RESET = 8'hff;
    localparam logic [7:0] FEATURE_RESET = 8'h00;
    localparam logic [8:0] CONTROL_RESET = 9'h000;
    localparam logic [3:0] DELAY_RESET = 4'h0;
    localparam int DELAY_LSB = 4;
    localparam int FC_IR_INV = 4;
    localparam int FC_RS485 = 5;
    localparam int FC_TABLE_LSB = 6;
    localparam logic [1:0] TABLE_D = 2'h3;
    localparam int CT_DTR = 0;
    localparam int CT_RTS = 1;
    localparam int CT_SEL_DTR = 2;
    localparam int CT_OUT2 = 3;
    localparam int CT_LOOP = 4;
    localparam int CT_MSI_EN = 5;
    localparam int CT_ENH_EN = 6;
    localparam int CT_AUTO_CTS = 7;
    localparam int CT_AUTO_RTS = 8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ums_modem_type;

    typedef enum logic [1:0] {
        DIR_IDLE = 2'b00,
        DIR_SEND = 2'b01,
        DIR_HOLD = 2'b11
    } ums_dir_type;

    // hysteresis in characters for each select code
    function automatic logic [5:0] ums_hyst(input logic [3:0] code);
        logic [5:0] h;
        h = 6'h00;
        case (code)
            4'h1: h = 6'h04;
            4'h2: h = 6'h06;
            4'h3: h = 6'h08;
            4'h4: h = 6'h08;
            4'h5: h = 6'h10;
            4'h6: h = 6'h18;
            4'h7: h = 6'h20;
            4'h8: h = 6'h28;
            4'h9: h = 6'h2c;
            4'ha: h = 6'h30;
            4'hb: h = 6'h34;
            4'hc: h = 6'h0c;
            4'hd: h = 6'h14;
            4'he: h = 6'h1c;
            4'hf: h = 6'h24;
            default: h = 6'h00;
        endcase
        return h;
    endfunction

endpackage

//--- logic/ums_modem_feature.sv
`timescale 1ns/1ps
// What this block does
// R01: clear-to-send change flag sets on any level change since last status read.
// R02: data-set-ready change flag sets on any level change since last status read.
// R03: ring change flag sets only when ring pin rises, ending ringing.
// R04: carrier-detect change flag sets on any level change since last read.
// R05: modem interrupt when any change flag set and its enable is set.
// R06: auto clear-to-send halts transmitter after current character while cts pin, or dsr pin with control bit 2 set, is high.
// R07: clear-to-send status is inverted pin, or request-to-send bit in loopback.
// R08: data-set-ready status is inverted pin, or terminal-ready bit in loopback.
// R09: ring status is inverted pin, or control bit 2 in loopback.
// R10: carrier status is inverted pin, or control bit 3 in loopback.
// R11: upper four status-address write bits set 0..15 bit-time turnaround delay.
// R12: turnaround delay writes accepted only while enhanced enable is set.
// R13: eight-bit read/write scratch register, reset to all ones.
// R14: hysteresis applies only with trigger table D selected.
// R15: hysteresis codes map to fixed plus/minus character counts.
// R16: hysteresis field resets to zero, next trigger level used.
// R17: infrared receive polarity bit selects normal or inverted receive input.
// R18: with rs485 off, transmit interrupt follows holding register empty.
// R19: with rs485 on, direction output falls after last stop bit leaves.
// R20: with rs485 on, direction output rises when a byte is loaded.
// R21: with rs485 on, transmit interrupt follows shift register empty.
// R22: tables A-C switch flow control one trigger level above and below.
// R23: low four status bits set when the matching input changes, the ring bit only on a pin rise.
// R24: loopback enabled by control bit 4, off after reset.
// R25: reading modem status clears all four change flags.
module ums_modem_feature
    import ums_pkg::*;
#(
    parameter int LEVEL_W = 7 // fifo level width, 0..64 must fit
) (
    input wire logic I_SYS_CLK, // 20 MHz clock
    input wire logic I_RESET, // synchronous, active high
    input wire logic I_PSEL, // apb select
    input wire logic I_PENABLE, // apb access phase
    input wire logic I_PWRITE, // apb direction
    input wire logic [7:0] I_PADDR, // apb byte address
    input wire logic [31:0] I_PWDATA, // apb write data
    output logic [31:0] O_PRDATA, // apb read data
    output logic O_PREADY, // apb ready
    output logic O_PSLVERR, // apb unmapped address
    input wire ums_modem_type I_MODEM_N, // modem pins, active low
    input wire logic I_RX, // serial receive pin
    input wire logic I_CHAR_IDLE, // transmitter between characters
    input wire logic I_THR_LOAD, // pulse: byte into holding reg or fifo
    input wire logic I_LAST_STOP, // pulse: last stop bit left shift reg
    input wire logic I_BIT_TICK, // pulse: one bit time elapsed
    input wire logic I_THR_EMPTY, // holding register or fifo empty
    input wire logic I_TSR_EMPTY, // shift register and fifo empty
    input wire logic [LEVEL_W-1:0] I_RX_LEVEL, // receive fifo fill
    input wire logic [LEVEL_W-1:0] I_RX_TRIG, // receive trigger level
    input wire logic [LEVEL_W-1:0] I_TRIG_UP, // next table level above
    input wire logic [LEVEL_W-1:0] I_TRIG_DN, // next table level below
    output logic O_MSI_IRQ, // modem status interrupt
    output logic O_TX_IRQ_SRC, // transmitter interrupt source
    output logic O_TX_HALT, // stop transmitter at char boundary
    output logic O_RTS_N, // rts pin / rs485 direction
    output logic O_DTR_N, // dtr pin
    output logic O_RX_IR, // receive data to infrared decoder
    output logic [1:0] O_TABLE_SEL // trigger table a..d
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (LEVEL_W < 7 || LEVEL_W > 16) begin : g_bad_width
        $error("LEVEL_W must be 7..16");
    end

    // ------------------------------------------------------------
    // registers and apb slave
    // ------------------------------------------------------------
    logic [7:0] scratch;
    logic [7:0] feature;
    logic [8:0] control;
    logic [3:0] delay;
    logic [3:0] delta;
    logic [3:0] status;
    logic [3:0] status_q;
    logic setup_ph;
    logic acc_ph;
    logic wr_en;
    logic status_rd;
    logic [7:0] next_rdata;
    logic mapped;

    assign setup_ph = I_PSEL & ~I_PENABLE;
    assign acc_ph = I_PSEL & I_PENABLE & O_PREADY;
    assign wr_en = acc_ph & I_PWRITE & ~O_PSLVERR;
    assign status_rd = acc_ph & ~I_PWRITE & (I_PADDR == ADDR_MODEM_STATUS);

    always_comb begin
        next_rdata = 8'h00;
        mapped = 1'b1;
        if (I_PADDR == ADDR_MODEM_STATUS) begin
            next_rdata = {status, delta};
        end else if (I_PADDR == ADDR_SCRATCH) begin
            next_rdata = scratch;
        end else if (I_PADDR == ADDR_FEATURE) begin
            next_rdata = feature;
        end else if (I_PADDR == ADDR_CONTROL) begin
            next_rdata = control[7:0];
        end else begin
            mapped = 1'b0;
        end
    end

    // one wait-free access phase: ready rises on the setup edge
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
        end else begin
            O_PREADY <= setup_ph;
            O_PSLVERR <= setup_ph & ~mapped;
            if (setup_ph && !I_PWRITE) begin
                O_PRDATA <= {24'h00_0000, next_rdata};
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            scratch <= SCRATCH_RESET; // R13
            feature <= FEATURE_RESET; // R16
            control <= CONTROL_RESET; // R24
            delay <= DELAY_RESET;
        end else if (wr_en) begin
            if (I_PADDR == ADDR_MODEM_STATUS && control[CT_ENH_EN]) begin
                delay <= I_PWDATA[DELAY_LSB +: 4]; // R11 R12
            end else if (I_PADDR == ADDR_SCRATCH) begin
                scratch <= I_PWDATA[7:0]; // R13
            end else if (I_PADDR == ADDR_FEATURE) begin
                feature <= I_PWDATA[7:0];
            end else if (I_PADDR == ADDR_CONTROL) begin
                control <= I_PWDATA[8:0];
            end
        end
    end

    // ------------------------------------------------------------
    // modem status and change flags
    // ------------------------------------------------------------
    always_comb begin
        if (control[CT_LOOP]) begin
            status = {control[CT_OUT2], control[CT_SEL_DTR],
                      control[CT_DTR], control[CT_RTS]}; // R07 R08 R09 R10 R24
        end else begin
            status = ~{I_MODEM_N.cd_n, I_MODEM_N.ri_n,
                       I_MODEM_N.dsr_n, I_MODEM_N.cts_n}; // R07 R08 R09 R10
        end
    end

    logic [3:0] change;
    // ring flag only when the pin rises, i.e. status bit falls
    assign change = {status[3] ^ status_q[3], status_q[2] & ~status[2],
                     status[1] ^ status_q[1], status[0] ^ status_q[0]}; // R03 R23

    // a change in the read cycle survives the read-clear
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            status_q <= 4'h0;
            delta <= 4'h0;
        end else begin
            status_q <= status;
            delta <= (delta & ~{4{status_rd}}) | change; // R01 R02 R04 R25
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_MSI_IRQ <= 1'b0;
        end else begin
            O_MSI_IRQ <= control[CT_MSI_EN] & (|delta); // R05
        end
    end

    // ------------------------------------------------------------
    // auto cts flow control
    // ------------------------------------------------------------
    logic halt_pin;
    assign halt_pin = control[CT_SEL_DTR] ? I_MODEM_N.dsr_n : I_MODEM_N.cts_n;

    // only updated between characters so a running one always finishes
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_TX_HALT <= 1'b0;
        end else if (I_CHAR_IDLE) begin
            O_TX_HALT <= control[CT_AUTO_CTS] & halt_pin; // R06
        end
    end

    // ------------------------------------------------------------
    // receive flow control thresholds
    // ------------------------------------------------------------
    logic [LEVEL_W:0] upper;
    logic [LEVEL_W:0] lower;
    logic [LEVEL_W:0] hyst;
    logic table_d;
    logic flow_n;

    assign table_d = feature[FC_TABLE_LSB +: 2] == TABLE_D;
    assign hyst = (LEVEL_W + 1)'(ums_hyst(feature[3:0])); // R15

    always_comb begin
        if (table_d && hyst != '0) begin
            upper = {1'b0, I_RX_TRIG} + hyst; // R14
            lower = ({1'b0, I_RX_TRIG} > hyst) ? {1'b0, I_RX_TRIG} - hyst : '0;
        end else begin
            upper = {1'b0, I_TRIG_UP}; // R16 R22
            lower = {1'b0, I_TRIG_DN}; // R22
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            flow_n <= 1'b0;
        end else if ({1'b0, I_RX_LEVEL} >= upper) begin
            flow_n <= 1'b1;
        end else if ({1'b0, I_RX_LEVEL} < lower) begin
            flow_n <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // rs485 direction control
    // ------------------------------------------------------------
    ums_dir_type dir_state;
    logic [3:0] hold_cnt;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET || !feature[FC_RS485]) begin
            dir_state <= DIR_IDLE;
            hold_cnt <= 4'h0;
        end else begin
            case (dir_state)
                DIR_IDLE: begin
                    if (I_THR_LOAD) begin
                        dir_state <= DIR_SEND; // R20
                    end
                end
                DIR_SEND: begin
                    if (I_LAST_STOP && !I_THR_LOAD) begin
                        hold_cnt <= delay; // R11
                        dir_state <= (delay == 4'h0) ? DIR_IDLE : DIR_HOLD; // R19
                    end
                end
                DIR_HOLD: begin
                    if (I_THR_LOAD) begin
                        dir_state <= DIR_SEND; // R20
                    end else if (I_BIT_TICK) begin
                        hold_cnt <= hold_cnt - 4'h1;
                        if (hold_cnt == 4'h1) begin
                            dir_state <= DIR_IDLE; // R11 R19
                        end
                    end
                end
                default: begin
                    dir_state <= DIR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin and status outputs
    // ------------------------------------------------------------
    logic rts_flow;
    assign rts_flow = control[CT_AUTO_RTS] & ~control[CT_SEL_DTR];

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_RTS_N <= 1'b1;
            O_DTR_N <= 1'b1;
            O_TX_IRQ_SRC <= 1'b0;
            O_RX_IR <= 1'b0;
            O_TABLE_SEL <= 2'h0;
        end else begin
            if (feature[FC_RS485]) begin
                O_RTS_N <= (dir_state != DIR_IDLE) | I_THR_LOAD; // R19 R20
                O_TX_IRQ_SRC <= I_TSR_EMPTY; // R21
            end else begin
                O_RTS_N <= rts_flow ? (flow_n | ~control[CT_RTS]) : ~control[CT_RTS];
                O_TX_IRQ_SRC <= I_THR_EMPTY; // R18
            end
            if (control[CT_AUTO_RTS] && control[CT_SEL_DTR]) begin
                O_DTR_N <= flow_n | ~control[CT_DTR];
            end else begin
                O_DTR_N <= ~control[CT_DTR];
            end
            O_RX_IR <= I_RX ^ feature[FC_IR_INV]; // R17
            O_TABLE_SEL <= feature[FC_TABLE_LSB +: 2]; // R22
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    a_msi_follows_flags: assert property ( // R05
        ##1 O_MSI_IRQ == $past(control[CT_MSI_EN] & (|delta)))
        else $error("modem interrupt does not follow flags and enable");

    a_cts_change_sets: assert property ( // R01
        $changed(status[0]) |=> delta[0])
        else $error("cts change flag not set");

    a_dsr_change_sets: assert property ( // R02
        $changed(status[1]) |=> delta[1])
        else $error("dsr change flag not set");

    a_ri_rise_only: assert property ( // R03
        (!delta[2] && !status_q[2] && !status[2]) |=> !delta[2])
        else $error("ring flag set without a pin rise");

    a_cd_change_sets: assert property ( // R04
        $changed(status[3]) |=> delta[3])
        else $error("carrier change flag not set");

    a_read_clears: assert property ( // R25
        (status_rd && change == 4'h0) |=> delta == 4'h0)
        else $error("status read did not clear flags");

    a_loop_cts_src: assert property ( // R07
        control[CT_LOOP] |-> status[0] == control[CT_RTS])
        else $error("loopback cts status wrong source");

    a_delay_locked: assert property ( // R12
        !control[CT_ENH_EN] |=> $stable(delay))
        else $error("delay changed while enhanced disabled");

    a_scratch_write: assert property ( // R13
        (wr_en && I_PADDR == ADDR_SCRATCH) |=> scratch == $past(I_PWDATA[7:0]))
        else $error("scratch write lost");

    sequence s_load_rs485;
        feature[FC_RS485] && I_THR_LOAD;
    endsequence

    a_rts_rises_load: assert property ( // R20
        s_load_rs485 ##1 feature[FC_RS485] |-> O_RTS_N)
        else $error("direction output not raised on load");

    sequence s_end_no_delay;
        feature[FC_RS485] && dir_state == DIR_SEND && I_LAST_STOP
            && !I_THR_LOAD && delay == 4'h0;
    endsequence

    a_rts_falls_end: assert property ( // R19
        s_end_no_delay ##1 (feature[FC_RS485] && !I_THR_LOAD) [*1] |=> !O_RTS_N)
        else $error("direction output not dropped after last stop bit");

    a_tx_irq_src: assert property ( // R21
        feature[FC_RS485] |=> O_TX_IRQ_SRC == $past(I_TSR_EMPTY))
        else $error("tx interrupt source not shift register empty");

    a_ri_rise_sets: assert property ( // R03
        (status_q[2] && !status[2]) |=> delta[2])
        else $error("ring flag not set on pin rise");

    a_halt_held_busy: assert property ( // R06
        !I_CHAR_IDLE |=> $stable(O_TX_HALT))
        else $error("transmit halt changed inside a character");

    a_delay_write: assert property ( // R11
        (wr_en && I_PADDR == ADDR_MODEM_STATUS && control[CT_ENH_EN])
            |=> delay == $past(I_PWDATA[DELAY_LSB +: 4]))
        else $error("turnaround delay write lost");

    a_hyst_table_d: assert property ( // R14
        !table_d |-> (upper == {1'b0, I_TRIG_UP} && lower == {1'b0, I_TRIG_DN}))
        else $error("hysteresis used outside table d");

endmodule // ums_modem_feature

//--- sim/ums_line_model.sv
`timescale 1ns/1ps
module ums_line_model
    import ums_pkg::*;
#(
    parameter int TICK_DIV = 4 // clocks per bit time, short to keep runs brief
) (
    input wire logic i_clk, // system clock
    input wire ums_modem_type i_pins_req, // levels the modem should show
    input wire logic i_rts_n, // transceiver direction from the block
    output ums_modem_type o_modem_n, // modem pins, active low
    output logic o_bit_tick, // one pulse per bit time
    output logic o_line_drive // transceiver drives the bus
);
    int div;

    initial begin
        o_modem_n = 4'hf;
        o_bit_tick = 1'b0;
        div = 0;
    end

    // pins follow the request one edge late, like a real cable
    always @(posedge i_clk) begin
        o_modem_n <= i_pins_req;
    end

    // bit clock of the transmitter runs free
    always @(posedge i_clk) begin
        div <= (div == TICK_DIV - 1) ? 0 : div + 1;
        o_bit_tick <= (div == TICK_DIV - 1);
    end

    // rts high means transmit on a half-duplex line
    assign o_line_drive = i_rts_n;
endmodule // ums_line_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ums_pkg::*;
    // ----------------------------------------
    // bench signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ums_modem_type pins_req = 4'hf;
    ums_modem_type modem_n;
    logic rx = 1'b1;
    logic char_idle = 1'b1;
    logic thr_load = 1'b0;
    logic last_stop = 1'b0;
    logic thr_empty = 1'b1;
    logic tsr_empty = 1'b0;
    logic [6:0] lvl = 7'h00;
    logic [6:0] trig = 7'h3c;
    logic [6:0] trig_up = 7'h3e;
    logic [6:0] trig_dn = 7'h32;
    logic bit_tick, msi, tx_src, halt, rts_n, dtr_n, rx_ir, drive;
    logic [1:0] tsel;
    logic [31:0] rd;
    logic err;
    logic [6:0] up, dn;
    int n_errors = 0;
    int samples_checked = 0;
    int cnt;
    typedef struct packed {logic [3:0] code; logic [6:0] hyst;} ums_row_type;
    // zero hysteresis means the next table level is used instead
    ums_row_type rows [16] = '{
        '{4'h0, 7'h00}, '{4'h1, 7'h04}, '{4'h2, 7'h06}, '{4'h3, 7'h08},
        '{4'h4, 7'h08}, '{4'h5, 7'h10}, '{4'h6, 7'h18}, '{4'h7, 7'h20},
        '{4'h8, 7'h28}, '{4'h9, 7'h2c}, '{4'ha, 7'h30}, '{4'hb, 7'h34},
        '{4'hc, 7'h0c}, '{4'hd, 7'h14}, '{4'he, 7'h1c}, '{4'hf, 7'h24}};

    always #25 clk = ~clk;

    ums_line_model #(.TICK_DIV(4)) model (.i_clk(clk), .i_pins_req(pins_req),
        .i_rts_n(rts_n), .o_modem_n(modem_n), .o_bit_tick(bit_tick), .o_line_drive(drive));

    ums_modem_feature #(.LEVEL_W(7)) dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_MODEM_N(modem_n),
        .I_RX(rx), .I_CHAR_IDLE(char_idle), .I_THR_LOAD(thr_load), .I_LAST_STOP(last_stop),
        .I_BIT_TICK(bit_tick), .I_THR_EMPTY(thr_empty), .I_TSR_EMPTY(tsr_empty),
        .I_RX_LEVEL(lvl), .I_RX_TRIG(trig), .I_TRIG_UP(trig_up), .I_TRIG_DN(trig_dn),
        .O_MSI_IRQ(msi), .O_TX_IRQ_SRC(tx_src), .O_TX_HALT(halt), .O_RTS_N(rts_n),
        .O_DTR_N(dtr_n), .O_RX_IR(rx_ir), .O_TABLE_SEL(tsel));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task report_and_stop();
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task set_lvl(input logic [6:0] v);
        @(posedge clk);
        lvl <= v;
        settle(4);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rchk(ADDR_SCRATCH, 32'hff);
        rchk(ADDR_FEATURE, 32'h00);
        rchk(ADDR_MODEM_STATUS, 32'h00);
        chk({rts_n, dtr_n, tsel}, 4'hc);
        apb(1'b1, ADDR_SCRATCH, 32'ha5);
        rchk(ADDR_SCRATCH, 32'ha5);
        apb(1'b1, ADDR_FEATURE, 32'hc0);
        rchk(ADDR_FEATURE, 32'hc0);
        chk(tsel, 2'h3);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            pins_req <= 4'hf & ~(4'h1 << i);
            settle(3);
            rchk(ADDR_MODEM_STATUS, (32'h10 << i) | ((i == 2) ? 32'h0 : (32'h1 << i)));
            pins_req <= 4'hf;
            settle(3);
            rchk(ADDR_MODEM_STATUS, 32'h1 << i);
            rchk(ADDR_MODEM_STATUS, 32'h0);
        end
        pins_req <= 4'he;
        settle(3);
        chk(msi, 1'b0);
        apb(1'b1, ADDR_CONTROL, 32'h020);
        settle(2);
        chk(msi, 1'b1);
        rchk(ADDR_MODEM_STATUS, 32'h11);
        settle(2);
        chk(msi, 1'b0);
        @(posedge clk);
        pins_req <= 4'hf;
        apb(1'b1, ADDR_CONTROL, 32'h01a);
        settle(2);
        apb(1'b0, ADDR_MODEM_STATUS, 32'h0);
        chk(rd & 32'hf0, 32'h90);
        apb(1'b1, ADDR_CONTROL, 32'h015);
        settle(2);
        apb(1'b0, ADDR_MODEM_STATUS, 32'h0);
        chk(rd & 32'hf0, 32'h60);
        apb(1'b1, ADDR_CONTROL, 32'h000);
        apb(1'b1, ADDR_MODEM_STATUS, 32'h50);
        apb(1'b1, ADDR_FEATURE, 32'h20);
        settle(2);
        chk(tx_src, 1'b0);
        @(posedge clk);
        thr_load <= 1'b1;
        @(posedge clk);
        thr_load <= 1'b0;
        settle(1);
        chk(rts_n, 1'b1);
        @(posedge clk);
        last_stop <= 1'b1;
        @(posedge clk);
        last_stop <= 1'b0;
        #1;
        chk(rts_n, 1'b1);
        settle(2);
        chk(rts_n, 1'b0);
        apb(1'b1, ADDR_CONTROL, 32'h040);
        apb(1'b1, ADDR_MODEM_STATUS, 32'hf0);
        @(posedge clk);
        thr_load <= 1'b1;
        @(posedge clk);
        thr_load <= 1'b0;
        settle(1);
        chk(rts_n, 1'b1);
        cnt = 0;
        while (bit_tick !== 1'b1 && cnt < 8) begin
            settle(1);
            cnt++;
        end
        if (bit_tick !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        // stop pulse lands between ticks so the count is unambiguous
        @(posedge clk);
        last_stop <= 1'b1;
        @(posedge clk);
        last_stop <= 1'b0;
        cnt = 0;
        for (int k = 0; k < 80 && cnt < 15; k++) begin
            settle(1);
            if (bit_tick === 1'b1) cnt++;
        end
        chk(cnt, 15);
        if (cnt != 15) begin
            report_and_stop();
        end
        chk(rts_n, 1'b1);
        settle(2);
        chk(rts_n, 1'b0);
        chk(drive, 1'b0);
        apb(1'b1, ADDR_FEATURE, 32'h00);
        settle(2);
        chk(tx_src, 1'b1);
        apb(1'b1, ADDR_CONTROL, 32'h080);
        settle(2);
        chk(halt, 1'b1);
        @(posedge clk);
        char_idle <= 1'b0;
        pins_req <= 4'he;
        settle(3);
        chk(halt, 1'b1);
        @(posedge clk);
        char_idle <= 1'b1;
        settle(2);
        chk(halt, 1'b0);
        apb(1'b1, ADDR_FEATURE, 32'h10);
        settle(2);
        chk(rx_ir, 1'b0);
        apb(1'b1, ADDR_FEATURE, 32'h00);
        settle(2);
        chk(rx_ir, 1'b1);
        @(posedge clk);
        rx <= 1'b0;
        settle(2);
        chk(rx_ir, 1'b0);
        apb(1'b1, ADDR_CONTROL, 32'h102);
        apb(1'b1, ADDR_FEATURE, 32'h05);
        set_lvl(trig_up);
        chk(rts_n, 1'b1);
        set_lvl(trig_dn - 7'h1);
        chk(rts_n, 1'b0);
        foreach (rows[r]) begin
            apb(1'b1, ADDR_FEATURE, {24'h0, 4'hc, rows[r].code});
            up = (rows[r].hyst != 0) ? trig + rows[r].hyst : trig_up;
            dn = (rows[r].hyst != 0) ? trig - rows[r].hyst : trig_dn;
            set_lvl(up - 7'h1);
            chk(rts_n, 1'b0);
            set_lvl(up);
            chk(rts_n, 1'b1);
            set_lvl(dn);
            chk(rts_n, 1'b1);
            set_lvl(dn - 7'h1);
            chk(rts_n, 1'b0);
        end
        // reset in mid-run: cts pin still low, so its status reads set
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(ADDR_SCRATCH, 32'hff);
        rchk(ADDR_FEATURE, 32'h00);
        apb(1'b0, ADDR_MODEM_STATUS, 32'h0);
        chk(rd & 32'hf0, 32'h10);
        chk({rts_n, dtr_n, tsel}, 4'hc);
        report_and_stop();
    end
endmodule // tb_top
